//--- bpfc_codec.v
// Builder of system-info tail and synchronisation unit field words
//
// Our own choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/10ps
`include "bpfc_consts.vh"

module bpfc_codec (
    // Clock and reset
    input  wire                         clk,
    input  wire                         arst_n,
    // Register port
    input  wire [3:0]                   addr,
    input  wire [31:0]                  wdata,
    input  wire                         wr_en,
    input  wire                         rd_en,
    output reg  [31:0]                  rdata_reg,
    // Build trigger and words
    input  wire                         build_start,
    input  wire                         sync_slot_ok,
    output reg  [`BPFC_SI_TAIL_W-1:0]   si_tail_reg,
    output reg  [`BPFC_SYNC_W-1:0]      sync_word_reg,
    output reg                          si_valid_reg,
    output reg                          sync_valid_reg,
    output reg                          opt_error_reg,
    // Decoded meaning of fields
    output reg  [4:0]                   frames_rsvd_reg,
    output reg                          immediate_ok_reg,
    output reg                          wait_rsvd_reg,
    output reg  [2:0]                   length_mult_reg,
    output reg                          predef_scramble_reg,
    output reg                          direct_mode_reg
);

    // ----------------------------------------------------------------
    // Software visible settings
    // ----------------------------------------------------------------
    reg                     key_sel_reg;
    reg [15:0]              key_val_reg;
    reg [1:0]               opt_sel_reg;
    reg [19:0]              map_reg;
    reg [3:0]               first_access_delay_reg;
    reg [3:0]               retry_wait_reg;
    reg [3:0]               max_random_tx_reg;
    reg                     factor_reg;
    reg [3:0]               slot_ptr_reg;
    reg [2:0]               min_prio_reg;
    reg [7:0]               security_reg;
    reg [1:0]               short_data_mode_reg;
    reg [3:0]               sys_code_reg;
    reg [5:0]               colour_reg;
    reg [1:0]               slot_num_reg;
    reg [4:0]               frame_num_reg;
    reg [5:0]               mframe_num_reg;
    reg [1:0]               share_reg;
    reg [2:0]               rsvd_code_reg;
    reg                     discontinuous_tx_flag_reg;
    reg                     frame18_ext_reg;
    reg [1:0]               phase_reg;
    reg                     sync_pending_reg;

    wire [4:0]              frames_lut;

    // ----------------------------------------------------------------
    // Register writes
    // ----------------------------------------------------------------
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            key_sel_reg               <= 1'b0;
            key_val_reg               <= 16'h0000;
            opt_sel_reg               <= `BPFC_OPT_ACCESS;
            map_reg                   <= 20'h00000;
            first_access_delay_reg    <= `BPFC_DELAY_ALWAYS;
            retry_wait_reg            <= 4'h1;
            max_random_tx_reg         <= 4'h0;
            factor_reg                <= 1'b0;
            slot_ptr_reg              <= `BPFC_SLOT_SAME;
            min_prio_reg              <= 3'h0;
            security_reg              <= 8'h00;
            short_data_mode_reg       <= 2'h1;
            sys_code_reg              <= 4'h0;
            colour_reg                <= 6'h00;
            slot_num_reg              <= 2'h0;
            frame_num_reg             <= 5'h01;
            mframe_num_reg            <= 6'h01;
            share_reg                 <= `BPFC_SHARE_CONT;
            rsvd_code_reg             <= 3'h0;
            discontinuous_tx_flag_reg <= 1'b0;
            frame18_ext_reg           <= 1'b0;
        end else if (wr_en) begin
            if (addr == `BPFC_ADDR_CTRL) begin
                key_sel_reg <= wdata[0];
            end else if (addr == `BPFC_ADDR_KEY) begin
                key_val_reg <= wdata[15:0];
            end else if (addr == `BPFC_ADDR_OPT) begin
                opt_sel_reg <= wdata[21:20];
                map_reg     <= wdata[19:0];
            end else if (addr == `BPFC_ADDR_ACCESS) begin
                first_access_delay_reg <= wdata[19:16];
                retry_wait_reg         <= wdata[15:12];
                max_random_tx_reg      <= wdata[11:8];
                factor_reg             <= wdata[7];
                slot_ptr_reg           <= wdata[6:3];
                min_prio_reg           <= wdata[2:0];
            end else if (addr == `BPFC_ADDR_EXT) begin
                security_reg        <= wdata[19:12];
                short_data_mode_reg <= wdata[11:10];
            end else if (addr == `BPFC_ADDR_SYNC0) begin
                sys_code_reg   <= wdata[22:19];
                colour_reg     <= wdata[18:13];
                slot_num_reg   <= wdata[12:11];
                frame_num_reg  <= wdata[10:6];
                mframe_num_reg <= wdata[5:0];
            end else if (addr == `BPFC_ADDR_SYNC1) begin
                share_reg                 <= wdata[6:5];
                rsvd_code_reg             <= wdata[4:2];
                discontinuous_tx_flag_reg <= wdata[1];
                frame18_ext_reg           <= wdata[0];
            end
        end
    end

    // ----------------------------------------------------------------
    // Field assembly
    // ----------------------------------------------------------------
    reg [`BPFC_OPT_W-1:0]   opt_field;
    reg                     opt_bad;
    reg                     sync_bad;

    always @* begin
        opt_bad = 1'b0;
        case (opt_sel_reg)
            `BPFC_OPT_EVEN_MAP, `BPFC_OPT_ODD_MAP: begin
                opt_field = map_reg;
                // Map only legal with discontinuous tx and control sharing
                opt_bad = !(discontinuous_tx_flag_reg
                            && share_reg == `BPFC_SHARE_MAIN_CC);
            end
            `BPFC_OPT_ACCESS: begin
                opt_field = {first_access_delay_reg, retry_wait_reg,
                             max_random_tx_reg, factor_reg,
                             slot_ptr_reg, min_prio_reg};
                opt_bad = (retry_wait_reg == `BPFC_WAIT_RSVD);
            end
            default: begin
                opt_field = {security_reg, short_data_mode_reg,
                             `BPFC_EXT_RSVD};
                opt_bad = (short_data_mode_reg == `BPFC_SDA_RSVD);
            end
        endcase
        // Out-of-range counters are refused rather than sent
        sync_bad = (frame_num_reg == 5'h00) || (frame_num_reg > `BPFC_FRAME_MAX)
                   || (mframe_num_reg == 6'h00)
                   || (mframe_num_reg > `BPFC_MFRAME_MAX);
    end

    // ----------------------------------------------------------------
    // Build sequencing
    // ----------------------------------------------------------------
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            si_tail_reg      <= {`BPFC_SI_TAIL_W{1'b0}};
            sync_word_reg    <= {`BPFC_SYNC_W{1'b0}};
            si_valid_reg     <= 1'b0;
            sync_valid_reg   <= 1'b0;
            opt_error_reg    <= 1'b0;
            phase_reg        <= 2'h0;
            sync_pending_reg <= 1'b0;
        end else begin
            si_valid_reg   <= 1'b0;
            sync_valid_reg <= 1'b0;
            if (build_start && phase_reg == 2'h0) begin
                phase_reg <= 2'h1;
            end else if (phase_reg == 2'h1) begin
                phase_reg     <= 2'h0;
                opt_error_reg <= opt_bad;
                if (!opt_bad) begin
                    // 1+16+2+20 bits: block total stays 124
                    si_tail_reg  <= {key_sel_reg, key_val_reg,
                                     opt_sel_reg, opt_field};
                    si_valid_reg <= 1'b1;
                end
                if (!sync_bad) begin
                    sync_word_reg <= {sys_code_reg, colour_reg, slot_num_reg,
                                      frame_num_reg, mframe_num_reg, share_reg,
                                      rsvd_code_reg, discontinuous_tx_flag_reg,
                                      frame18_ext_reg, `BPFC_SYNC_RSVD_BIT};
                    sync_pending_reg <= 1'b1;
                end
            end
            // Sync word released only into a sync burst slot
            if (sync_pending_reg && sync_slot_ok) begin
                sync_valid_reg   <= 1'b1;
                sync_pending_reg <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // Decoded meanings
    // ----------------------------------------------------------------
    bpfc_frames_rom u_frames (
        .clk        (clk),
        .arst_n     (arst_n),
        .code       (rsvd_code_reg),
        .frames_reg (frames_lut)
    );

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            frames_rsvd_reg     <= 5'h00;
            immediate_ok_reg    <= 1'b0;
            wait_rsvd_reg       <= 1'b0;
            length_mult_reg     <= 3'h1;
            predef_scramble_reg <= 1'b1;
            direct_mode_reg     <= 1'b0;
        end else begin
            // Meaningless outside control channel sharing, so shown as zero
            frames_rsvd_reg <= (share_reg == `BPFC_SHARE_MAIN_CC) ?
                               frames_lut : 5'h00;
            immediate_ok_reg <= (first_access_delay_reg == `BPFC_DELAY_IMMED);
            wait_rsvd_reg    <= (retry_wait_reg == `BPFC_WAIT_RSVD);
            length_mult_reg  <= factor_reg ? 3'h4 : 3'h1;
            predef_scramble_reg <= (colour_reg == 6'h00);
            direct_mode_reg  <= (sys_code_reg[3:2] == 2'h3);
        end
    end

    // ----------------------------------------------------------------
    // Register reads
    // ----------------------------------------------------------------
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rdata_reg <= 32'h00000000;
        end else if (rd_en) begin
            if (addr == `BPFC_ADDR_CTRL) begin
                rdata_reg <= {31'h00000000, key_sel_reg};
            end else if (addr == `BPFC_ADDR_KEY) begin
                rdata_reg <= {16'h0000, key_val_reg};
            end else if (addr == `BPFC_ADDR_OPT) begin
                rdata_reg <= {10'h000, opt_sel_reg, map_reg};
            end else if (addr == `BPFC_ADDR_ACCESS) begin
                rdata_reg <= {12'h000, first_access_delay_reg, retry_wait_reg,
                              max_random_tx_reg, factor_reg, slot_ptr_reg,
                              min_prio_reg};
            end else if (addr == `BPFC_ADDR_EXT) begin
                rdata_reg <= {12'h000, security_reg, short_data_mode_reg,
                              `BPFC_EXT_RSVD};
            end else if (addr == `BPFC_ADDR_SYNC0) begin
                rdata_reg <= {9'h000, sys_code_reg, colour_reg, slot_num_reg,
                              frame_num_reg, mframe_num_reg};
            end else if (addr == `BPFC_ADDR_SYNC1) begin
                rdata_reg <= {25'h0000000, share_reg, rsvd_code_reg,
                              discontinuous_tx_flag_reg, frame18_ext_reg};
            end else if (addr == `BPFC_ADDR_STATUS) begin
                rdata_reg <= {28'h0000000, sync_bad, opt_bad, sync_pending_reg,
                              opt_error_reg};
            end else if (addr == `BPFC_ADDR_SI_WORD) begin
                rdata_reg <= si_tail_reg[31:0];
            end else if (addr == `BPFC_ADDR_SY_WORD) begin
                rdata_reg <= {1'b0, sync_word_reg};
            end else begin
                rdata_reg <= 32'h00000000;
            end
        end
    end

endmodule

//--- bpfc_consts.vh
// Field layout and code constants for the broadcast unit field builder
`ifndef BPFC_CONSTS_VH
`define BPFC_CONSTS_VH

// ----------------------------------------------------------------
// Register map (word index on the plain port)
// ----------------------------------------------------------------
`define BPFC_ADDR_CTRL      4'h0
`define BPFC_ADDR_KEY       4'h1
`define BPFC_ADDR_OPT       4'h2
`define BPFC_ADDR_ACCESS    4'h3
`define BPFC_ADDR_EXT       4'h4
`define BPFC_ADDR_SYNC0     4'h5
`define BPFC_ADDR_SYNC1     4'h6
`define BPFC_ADDR_STATUS    4'h7
`define BPFC_ADDR_SI_WORD   4'h8
`define BPFC_ADDR_SY_WORD   4'h9

// ----------------------------------------------------------------
// Widths
// ----------------------------------------------------------------
`define BPFC_SI_TAIL_W      39
`define BPFC_OPT_W          20
`define BPFC_SYNC_W         31
`define BPFC_SI_BLOCK_W     124
`define BPFC_KEY_W          16

// ----------------------------------------------------------------
// Optional field selector codes
// ----------------------------------------------------------------
`define BPFC_OPT_EVEN_MAP   2'h0
`define BPFC_OPT_ODD_MAP    2'h1
`define BPFC_OPT_ACCESS     2'h2
`define BPFC_OPT_EXT        2'h3

// ----------------------------------------------------------------
// Sharing mode codes
// ----------------------------------------------------------------
`define BPFC_SHARE_CONT     2'h0
`define BPFC_SHARE_CARRIER  2'h1
`define BPFC_SHARE_MAIN_CC  2'h2
`define BPFC_SHARE_TRAFFIC  2'h3

// ----------------------------------------------------------------
// Field codes
// ----------------------------------------------------------------
`define BPFC_DELAY_ALWAYS   4'h0
`define BPFC_DELAY_IMMED    4'hF
`define BPFC_WAIT_RSVD      4'h0
`define BPFC_SLOT_SAME      4'h0
`define BPFC_SLOT_FOUR      4'h1
`define BPFC_SLOT_ALL       4'hF
`define BPFC_SDA_RSVD       2'h0
`define BPFC_SYSCODE_MAX    4'h2
`define BPFC_FRAME_MAX      5'h12
`define BPFC_MFRAME_MAX     6'h3C
`define BPFC_EXT_RSVD       10'h000
`define BPFC_SYNC_RSVD_BIT  1'h0

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define BPFC_BUILD_CYCLES   2

`endif

//--- bpfc_frames_rom.v
// Reserved-frames code to frame count lookup, registered output
`timescale 1ns/10ps

module bpfc_frames_rom (
    // Clock and reset
    input  wire       clk,
    input  wire       arst_n,
    // Lookup
    input  wire [2:0] code,
    output reg  [4:0] frames_reg
);

    reg [4:0] frames_next;

    always @* begin
        case (code)
            3'h0:    frames_next = 5'h01;
            3'h1:    frames_next = 5'h02;
            3'h2:    frames_next = 5'h03;
            3'h3:    frames_next = 5'h04;
            3'h4:    frames_next = 5'h06;
            3'h5:    frames_next = 5'h09;
            3'h6:    frames_next = 5'h0C;
            default: frames_next = 5'h12;
        endcase
    end

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            frames_reg <= 5'h01;
        end else begin
            frames_reg <= frames_next;
        end
    end

endmodule

//--- bpfc_codec_assertions.sv
// Port checks for the broadcast unit field builder
`timescale 1ns/10ps
`include "bpfc_consts.vh"

module bpfc_codec_checker (
    // Clock and reset
    input wire        clk,
    input wire        arst_n,
    // Build side
    input wire        build_start,
    input wire        sync_slot_ok,
    input wire [38:0] si_tail_reg,
    input wire [30:0] sync_word_reg,
    input wire        si_valid_reg,
    input wire        sync_valid_reg,
    input wire        opt_error_reg,
    input wire [2:0]  length_mult_reg
);
    // ------------------------------
    // Field views
    // ------------------------------
    wire [1:0]  sel = si_tail_reg[21:20];
    wire [19:0] opt = si_tail_reg[19:0];
    wire [4:0]  frm = sync_word_reg[18:14];
    wire [5:0]  mfr = sync_word_reg[13:8];

    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    // ------------------------------
    // Assertions
    // ------------------------------
    chk_si_after_start: assert property (si_valid_reg |-> $past(build_start, 2))
        else $error("si valid without start");
    chk_si_single: assert property (si_valid_reg |=> !si_valid_reg)
        else $error("si valid too long");
    chk_si_clean: assert property (si_valid_reg |-> !opt_error_reg)
        else $error("si sent with error flag");
    chk_tail_hold: assert property ($changed(si_tail_reg) |-> si_valid_reg)
        else $error("si tail moved silently");
    chk_ext_zero: assert property (si_valid_reg && sel == `BPFC_OPT_EXT |-> opt[9:0] == 10'h000)
        else $error("ext reserved bits set");
    chk_ext_mode: assert property (si_valid_reg && sel == `BPFC_OPT_EXT |-> opt[11:10] != 2'h0)
        else $error("reserved addressing sent");
    chk_wait_code: assert property (si_valid_reg && sel == `BPFC_OPT_ACCESS |-> opt[15:12] != 4'h0)
        else $error("reserved wait sent");
    chk_sync_slot: assert property (sync_valid_reg |-> $past(sync_slot_ok))
        else $error("sync outside sync slot");
    // Word loads at build time but waits for a sync slot before its pulse
    chk_sync_hold: assert property ($changed(sync_word_reg) |->
        $past(build_start, 2) ##[0:20] sync_valid_reg)
        else $error("sync word moved silently");
    chk_sync_rsvd: assert property (sync_valid_reg |-> sync_word_reg[0] == 1'b0)
        else $error("sync reserved bit set");
    chk_sync_range: assert property (sync_valid_reg |-> frm inside {[1:18]} && mfr inside {[1:60]})
        else $error("sync counter out of range");
    chk_len_mult: assert property (length_mult_reg == 3'h1 || length_mult_reg == 3'h4)
        else $error("bad length factor");
endmodule

//--- bpfc_ms_model.sv
// Mobile receiver model: sync slot pacing and reserved-frame decode
`timescale 1ns/10ps

module bpfc_ms_model (
    // Clock and reset
    input  wire        clk,
    input  wire        arst_n,
    // Pace and slot
    input  wire        slow,
    output wire        sync_slot_ok,
    // Received sync unit
    input  wire        sync_valid_reg,
    input  wire [30:0] sync_word_reg,
    output reg  [4:0]  rx_frames_reg
);
    localparam [39:0] FTAB = {5'h12, 5'h0C, 5'h09, 5'h06, 5'h04, 5'h03, 5'h02, 5'h01};
    reg [3:0] gap_reg;
    reg       slot_reg;

    // Slow pace stretches the wait for a sync burst
    assign sync_slot_ok = slot_reg;
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            gap_reg <= 4'h0;
            slot_reg <= 1'b0;
            rx_frames_reg <= 5'h00;
        end else begin
            gap_reg <= (gap_reg >= (slow ? 4'hF : 4'h3)) ? 4'h0 : gap_reg + 4'h1;
            slot_reg <= (gap_reg == 4'h0);
            if (sync_valid_reg) begin
                rx_frames_reg <= (sync_word_reg[7:6] == 2'h2) ?
                    FTAB[sync_word_reg[5:3]*5 +: 5] : 5'h00;
            end
        end
    end
endmodule

//--- bpfc_codec_bench.sv
// Self-checking bench for the broadcast unit field builder
`timescale 1ns/10ps
`include "bpfc_consts.vh"

module bpfc_codec_bench;
    // ------------------------------
    // Signals and scoreboard
    // ------------------------------
    localparam [39:0] FTAB = {5'h12, 5'h0C, 5'h09, 5'h06, 5'h04, 5'h03, 5'h02, 5'h01};
    reg          clk = 1'b0;
    reg          arst_n = 1'b0;
    reg  [3:0]   addr = 4'h0;
    reg  [31:0]  wdata = 32'h0;
    reg          wr_en = 1'b0;
    reg          rd_en = 1'b0;
    reg          build_start = 1'b0;
    reg          slow = 1'b0;
    reg          rd_d = 1'b0;
    reg  [31:0]  seed = 32'h2ABC;
    wire         sync_slot_ok, si_valid_reg, sync_valid_reg, opt_error_reg;
    wire         immediate_ok_reg, wait_rsvd_reg, predef_scramble_reg, direct_mode_reg;
    wire [31:0]  rdata_reg;
    wire [38:0]  si_tail_reg;
    wire [30:0]  sync_word_reg;
    wire [4:0]   frames_rsvd_reg, rx_frames_reg;
    wire [2:0]   length_mult_reg;
    logic [38:0] si_q[$], sy_q[$], rd_q[$];
    logic [38:0] exp_si, last_si = 39'h0;
    logic [31:0] r, acc, ext, mp, s0, s1, last_sy = 32'h0;
    logic [3:0]  sys;
    logic [4:0]  fr;
    logic [5:0]  mf;
    logic [1:0]  sh, sel;
    logic        discontinuous_tx_flag, si_ok, sok;
    int          n_fail = 0;
    int          checks = 0;
    int          j;

    always #20 clk = ~clk;

    bpfc_codec uut (
        .clk(clk), .arst_n(arst_n), .addr(addr), .wdata(wdata), .wr_en(wr_en),
        .rd_en(rd_en), .rdata_reg(rdata_reg), .build_start(build_start),
        .sync_slot_ok(sync_slot_ok), .si_tail_reg(si_tail_reg),
        .sync_word_reg(sync_word_reg), .si_valid_reg(si_valid_reg),
        .sync_valid_reg(sync_valid_reg), .opt_error_reg(opt_error_reg),
        .frames_rsvd_reg(frames_rsvd_reg), .immediate_ok_reg(immediate_ok_reg),
        .wait_rsvd_reg(wait_rsvd_reg), .length_mult_reg(length_mult_reg),
        .predef_scramble_reg(predef_scramble_reg), .direct_mode_reg(direct_mode_reg));

    bpfc_ms_model u_ms (
        .clk(clk), .arst_n(arst_n), .slow(slow), .sync_slot_ok(sync_slot_ok),
        .sync_valid_reg(sync_valid_reg), .sync_word_reg(sync_word_reg),
        .rx_frames_reg(rx_frames_reg));

    // ------------------------------
    // Tasks
    // ------------------------------
    function logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    function logic [31:0] dflt(input logic [3:0] a);
        case (a)
            4'h2: dflt = 32'h00200000;
            4'h3: dflt = 32'h00001000;
            4'h4: dflt = 32'h00000400;
            4'h5: dflt = 32'h00000041;
            default: dflt = 32'h0;
        endcase
    endfunction

    task automatic chk(input logic [38:0] got, input logic [38:0] exp);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task report_and_stop;
        $display("checks %0d mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask

    task rd(input logic [3:0] a, input logic [31:0] e);
        rd_q.push_back({7'h0, e});
        @(posedge clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
    endtask

    // Bounded wait: refused sync units never pulse
    task build(input logic ok);
        int i;
        @(posedge clk);
        build_start <= 1'b1;
        @(posedge clk);
        build_start <= 1'b0;
        for (i = 0; i < 40 && sync_valid_reg !== 1'b1; i++) begin
            @(negedge clk);
        end
        if (ok && i == 40) begin
            n_fail++;
            $display("Error %0t: no sync unit", $time);
            report_and_stop;
        end
        repeat (3) @(posedge clk);
    endtask

    // ------------------------------
    // Monitor
    // ------------------------------
    always @(posedge clk) begin
        rd_d <= rd_en;
        if (rd_d) chk(rdata_reg, rd_q.pop_front());
        if (si_valid_reg === 1'b1) begin
            chk(si_q.size() > 0, 1'b1);
            if (si_q.size() > 0) chk(si_tail_reg, si_q.pop_front());
        end
        if (sync_valid_reg === 1'b1) begin
            chk(sy_q.size() > 0, 1'b1);
            if (sy_q.size() > 0) chk(sync_word_reg, sy_q.pop_front());
        end
    end

    // ------------------------------
    // Main sequence
    // ------------------------------
    initial begin
        repeat (5) @(posedge clk);
        arst_n <= 1'b1;
        @(negedge clk);
        chk(length_mult_reg, 3'h1);
        chk(predef_scramble_reg, 1'b1);
        for (j = 0; j < 16; j++) begin
            rd(j[3:0], dflt(j[3:0]));
        end
        for (j = 0; j < 16; j++) begin
            r = rnd();
            acc = rnd();
            ext = rnd();
            mp = rnd();
            sh = j[1:0];
            sel = (j < 8) ? (j[1:0] ^ (j[2] ? 2'h3 : 2'h2)) : (j[0] ? 2'h3 : r[1:0]);
            discontinuous_tx_flag = (j < 8) | r[2];
            sys = r[4] ? {2'h3, r[6:5]} : {2'h0, r[6], r[5] & ~r[6]};
            fr = (j == 1) ? 5'h12 : (j == 9) ? 5'h00 : (j == 12) ? 5'h13 : 5'(r[11:7] % 18) + 5'h01;
            mf = (j == 1) ? 6'h3C : (j == 15) ? 6'h3D : 6'(r[17:12] % 60) + 6'h01;
            if (j < 2) acc[19:16] = {4{j[0]}};
            if (j < 3) acc[6:3] = (j == 2) ? 4'h1 : {4{j[0]}};
            if (j == 5) acc[15:12] = 4'h0;
            ext[11:10] = (j < 8) ? j[2:1] : j[1:0];
            s0 = {9'h0, sys, (j == 0) ? 6'h00 : r[23:18], r[25:24], fr, mf};
            s1 = {25'h0, sh, j[2:0], discontinuous_tx_flag, r[26]};
            sok = fr >= 5'h01 && fr <= 5'h12 && mf >= 6'h01 && mf <= 6'h3C;
            si_ok = sel[1] ? (sel[0] ? ext[11:10] != 2'h0 : acc[15:12] != 4'h0) : (sh == 2'h2 && discontinuous_tx_flag);
            exp_si = {r[27], mp[31:16], sel, (sel == 2'h3) ? {ext[19:10], 10'h000} :
                      (sel == 2'h2) ? acc[19:0] : mp[19:0]};
            wr(`BPFC_ADDR_CTRL, {31'h0, r[27]});
            wr(`BPFC_ADDR_KEY, {16'h0, mp[31:16]});
            wr(`BPFC_ADDR_OPT, {10'h0, sel, mp[19:0]});
            wr(`BPFC_ADDR_ACCESS, acc);
            wr(`BPFC_ADDR_EXT, ext);
            wr(`BPFC_ADDR_SYNC0, s0);
            wr(`BPFC_ADDR_SYNC1, s1);
            repeat (3) @(negedge clk);
            chk(immediate_ok_reg, acc[19:16] == 4'hF);
            chk(wait_rsvd_reg, acc[15:12] == 4'h0);
            chk(length_mult_reg, acc[7] ? 3'h4 : 3'h1);
            chk(frames_rsvd_reg, (sh == 2'h2) ? FTAB[j[2:0]*5 +: 5] : 5'h00);
            chk(predef_scramble_reg, s0[18:13] == 6'h00);
            chk(direct_mode_reg, sys[3:2] == 2'h3);
            if (si_ok) si_q.push_back(exp_si);
            if (si_ok) last_si = exp_si;
            if (sok) sy_q.push_back({s0[22:0], s1[6:0], 1'b0});
            if (sok) last_sy = {1'b0, s0[22:0], s1[6:0], 1'b0};
            slow <= j[0];
            build(sok);
            chk(opt_error_reg, !si_ok);
            if (sok) chk(rx_frames_reg, (sh == 2'h2) ? FTAB[j[2:0]*5 +: 5] : 5'h00);
            rd(`BPFC_ADDR_SI_WORD, last_si[31:0]);
            rd(`BPFC_ADDR_SY_WORD, last_sy);
        end
        repeat (4) @(posedge clk);
        chk(si_q.size() + sy_q.size() + rd_q.size(), 39'h0);
        report_and_stop;
    end
endmodule

bind bpfc_codec bpfc_codec_checker u_chk (
    .clk(clk), .arst_n(arst_n), .build_start(build_start), .sync_slot_ok(sync_slot_ok),
    .si_tail_reg(si_tail_reg), .sync_word_reg(sync_word_reg), .si_valid_reg(si_valid_reg),
    .sync_valid_reg(sync_valid_reg), .opt_error_reg(opt_error_reg),
    .length_mult_reg(length_mult_reg));
